// >>> verilog/qos_ot_pkg.sv
package qos_ot_pkg;

   // Slave interfaces; the first ones are the lite ports
   localparam int NUM_PORTS = 5;
   localparam int NUM_LITE  = 3;

   // Address map: one 16-byte block per slave interface
   localparam logic [4:0]  PORT_REGION     = 5'h00;
   localparam logic [3:0]  WQOS_OFFSET     = 4'h0;
   localparam logic [3:0]  CONTROL_OFFSET  = 4'h4;
   localparam logic [3:0]  LIMIT_OFFSET    = 4'h8;
   localparam logic [11:0] SECURE_OFFSET   = 12'h050;

   // Field positions
   localparam int WQOS_FIXED_LSB     = 0;
   localparam int WQOS_LIVE_LSB      = 8;
   localparam int CTRL_QUIESCE_BIT   = 21;
   localparam int CTRL_RD_PERIOD_BIT = 20;
   localparam int CTRL_WR_PERIOD_BIT = 16;
   localparam int CTRL_OT_RD_BIT     = 3;
   localparam int CTRL_OT_WR_BIT     = 2;
   localparam int CTRL_QV_RD_BIT     = 1;
   localparam int CTRL_QV_WR_BIT     = 0;
   localparam int LIMIT_RD_INT_LSB   = 24;
   localparam int LIMIT_RD_FRAC_LSB  = 16;
   localparam int LIMIT_WR_INT_LSB   = 8;
   localparam int LIMIT_WR_FRAC_LSB  = 0;
   localparam int SECURE_GRANT_BIT   = 0;
   localparam int PROT_NONSECURE_BIT = 1;

   // Writable bits; everything else except the live QoS field reads zero
   localparam logic [31:0] WQOS_WRITE_MASK   = 32'h0000_000f;
   localparam logic [31:0] CTRL_MASK_LITE    = 32'h0031_000f;
   localparam logic [31:0] CTRL_MASK_ACE     = 32'h0031_0003;
   localparam logic [31:0] LIMIT_WRITE_MASK  = 32'h3fff_3fff;

   // Reset values
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [3:0]  QOS_RESET = 4'h0;

   // Build-time outstanding depths
   localparam logic [6:0] OT_RD_HW_MAX = 7'h20;
   localparam logic [6:0] OT_WR_HW_MAX = 7'h20;

endpackage

// >>> verilog/ot_limit_if.sv
`timescale 1ns/10ps
interface ot_limit_if;
   logic [5:0] int_part;
   logic [7:0] frac_part;
   logic       enable;
   logic       issue;
   logic [6:0] limit;
   logic       active;

   modport owner (output int_part, frac_part, enable, issue,
                  input  limit, active);
   modport limiter (input  int_part, frac_part, enable, issue,
                    output limit, active);
endinterface

// >>> verilog/ot_limit_average.sv
`timescale 1ns/10ps
module ot_limit_average
   import qos_ot_pkg::*;
#(
   parameter logic [6:0] HW_MAX = OT_RD_HW_MAX
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   ot_limit_if.limiter lim
);

   typedef struct packed {
      logic [7:0] acc;
      logic       bonus;
      logic [6:0] limit;
      logic       active;
   } limiter_state_type;

   limiter_state_type state;
   limiter_state_type next_state;
   logic              prog_off;
   logic              over;

   always_comb
   begin
      next_state = state;
      prog_off = (lim.int_part == 6'h00) && (lim.frac_part == 8'h00);
      over = ({1'b0, lim.int_part} > HW_MAX)
             || (({1'b0, lim.int_part} == HW_MAX)
                 && (lim.frac_part != 8'h00));
      if (lim.frac_part == 8'h00)
      begin
         next_state.acc = 8'h00; // see RQ15
         next_state.bonus = 1'b0; // see RQ15
      end
      else if (lim.issue)
      begin
         {next_state.bonus, next_state.acc} =
            {1'b0, state.acc} + {1'b0, lim.frac_part}; // see RQ20
      end
      next_state.active = lim.enable && !prog_off; // see RQ14
      if (!next_state.active || over)
         next_state.limit = HW_MAX; // see RQ16
      else
         next_state.limit = {1'b0, lim.int_part} + {6'h00, next_state.bonus};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= '0;
      else if (clk_en)
         state <= next_state;
   end

   assign lim.limit = state.limit;
   assign lim.active = state.active;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence carry_issue;
      clk_en && lim.issue && (lim.frac_part != 8'h00)
      && ({1'b0, state.acc} + {1'b0, lim.frac_part} > 9'h0ff);
   endsequence

   sequence bonus_seen;
      state.bonus ##0 (state.limit == HW_MAX
                       || state.limit != {1'b0, lim.int_part});
   endsequence

   chk_fallback_limit: assert property ( // see RQ14
      clk_en && (!lim.enable || prog_off) |=> state.limit == HW_MAX
                                              && !state.active)
      else $error("limit not at build-time depth while unregulated");

   chk_depth_ceiling: assert property ( // see RQ16
      state.limit <= HW_MAX)
      else $error("limit above build-time depth");

   chk_whole_only: assert property ( // see RQ15
      clk_en && lim.enable && !prog_off && !over
      && lim.frac_part == 8'h00
      |=> state.limit == {1'b0, $past(lim.int_part)})
      else $error("fraction applied while fractional part is zero");

   chk_fraction_carry: assert property ( // see RQ20
      carry_issue ##1 (lim.enable && !prog_off && !over) |-> bonus_seen)
      else $error("accumulator carry did not grant one extra");

endmodule

// >>> verilog/qos_value_select.sv
`timescale 1ns/10ps
module qos_value_select
(
   input  wire logic       fixed_select,
   input  wire logic [3:0] fixed_value,
   input  wire logic       regulate,
   input  wire logic [3:0] regulated,
   input  wire logic [3:0] qos_min,
   input  wire logic [3:0] qos_max,
   input  wire logic [3:0] incoming,
   output logic      [3:0] applied,
   output logic      [3:0] live
);

   logic [3:0] clamped;

   always_comb
   begin
      if (regulated > qos_max)
         clamped = qos_max; // see RQ19
      else if (regulated < qos_min)
         clamped = qos_min; // see RQ19
      else
         clamped = regulated;
      if (!fixed_select)
         applied = incoming;
      else if (!regulate)
         applied = fixed_value; // see RQ1
      else if (incoming == 4'h0)
         applied = clamped;
      else
         applied = incoming;
      live = (fixed_select && regulate) ? clamped : 4'h0; // see RQ2
   end

endmodule

// >>> verilog/qos_ot_regulation_config.sv
// Operation
// RQ1: Fixed write QoS drives requests when selected and regulation is off.
// RQ2: Read-only field shows regulated QoS applied to zero-QoS writes.
// RQ3: Non-secure accesses refused unless secure access has been granted.
// RQ4: Control bit 21 picks normal or quiesce-high bandwidth mode.
// RQ5: Control bit 20 picks latency or period mode for reads.
// RQ6: Control bit 16 picks latency or period mode for writes.
// RQ7: Bit 3 enables read outstanding regulation, lite ports only.
// RQ8: Bit 2 enables write outstanding regulation, lite ports only.
// RQ9: Bit 1 enables read QoS value regulation.
// RQ10: Bit 0 enables write QoS value regulation.
// RQ11: Outstanding enable changes wait until the port is idle.
// RQ12: Read limit is integer 29:24 plus fraction 23:16 over 256.
// RQ13: Write limit is integer 13:8 plus fraction 7:0 over 256.
// RQ14: Zero integer and fraction means build-time limits apply.
// RQ15: Zero fraction means no fractional regulation.
// RQ16: Limits above build-time depth are ignored.
// RQ17: Limit registers exist only for the three lite ports.
// RQ18: Zero regulator target means no regulation on that channel.
// RQ19: Regulated QoS clamped between programmable minimum and maximum.
// RQ20: Fraction realised by alternating integer and integer plus one.
// RQ21: Reserved bits read zero; fields reset to zero.
`timescale 1ns/10ps
module qos_ot_regulation_config
   import qos_ot_pkg::*;
(
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        clk_en,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [11:0]                 paddr,
   input  wire logic [31:0]                 pwdata,
   input  wire logic [2:0]                  pprot,
   output logic      [31:0]                 prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire logic [NUM_PORTS-1:0]        qos_fixed_select,
   input  wire logic [NUM_PORTS-1:0][3:0]   write_qos_in,
   input  wire logic [NUM_PORTS-1:0][3:0]   regulated_wqos,
   input  wire logic [NUM_PORTS-1:0][3:0]   wqos_min,
   input  wire logic [NUM_PORTS-1:0][3:0]   wqos_max,
   input  wire logic [NUM_PORTS-1:0][11:0]  rd_target,
   input  wire logic [NUM_PORTS-1:0][11:0]  wr_target,
   output logic      [NUM_PORTS-1:0][3:0]   write_qos_out,
   output logic      [NUM_PORTS-1:0]        quiesce_high,
   output logic      [NUM_PORTS-1:0]        rd_period_mode,
   output logic      [NUM_PORTS-1:0]        wr_period_mode,
   output logic      [NUM_PORTS-1:0]        rd_qv_enable,
   output logic      [NUM_PORTS-1:0]        wr_qv_enable,
   input  wire logic [NUM_LITE-1:0]         ot_rd_idle,
   input  wire logic [NUM_LITE-1:0]         ot_wr_idle,
   input  wire logic [NUM_LITE-1:0]         ar_issue,
   input  wire logic [NUM_LITE-1:0]         aw_issue,
   output logic      [NUM_LITE-1:0][6:0]    ot_rd_limit,
   output logic      [NUM_LITE-1:0][6:0]    ot_wr_limit,
   output logic      [NUM_LITE-1:0]         ot_rd_limited,
   output logic      [NUM_LITE-1:0]         ot_wr_limited
);

   typedef struct packed {
      logic [NUM_PORTS-1:0][3:0]  wqos_fixed;
      logic [NUM_PORTS-1:0][31:0] control;
      logic [NUM_LITE-1:0][31:0]  limit;
      logic [NUM_LITE-1:0]        ot_rd_on;
      logic [NUM_LITE-1:0]        ot_wr_on;
      logic                       secure_grant;
      logic [NUM_PORTS-1:0][3:0]  wqos_out;
      logic [31:0]                rdata;
   } bank_state_type;

   bank_state_type             state;
   bank_state_type             next_state;
   logic [2:0]                 port_idx;
   logic [3:0]                 reg_off;
   logic                       in_ports;
   logic                       is_wqos;
   logic                       is_ctrl;
   logic                       is_limit;
   logic                       is_secure;
   logic                       mapped;
   logic                       permitted;
   logic                       setup;
   logic                       wr_fire;
   logic [31:0]                read_value;
   logic [NUM_PORTS-1:0]       wr_regulate;
   logic [NUM_PORTS-1:0][3:0]  applied;
   logic [NUM_PORTS-1:0][3:0]  live;

   // Address decode
   assign port_idx = paddr[6:4];
   assign reg_off = paddr[3:0];
   assign in_ports = (paddr[11:7] == PORT_REGION)
                     && (port_idx < 3'(NUM_PORTS));
   assign is_wqos = in_ports && (reg_off == WQOS_OFFSET);
   assign is_ctrl = in_ports && (reg_off == CONTROL_OFFSET);
   assign is_limit = in_ports && (reg_off == LIMIT_OFFSET)
                     && (port_idx < 3'(NUM_LITE)); // see RQ17
   assign is_secure = (paddr == SECURE_OFFSET);
   assign mapped = is_wqos || is_ctrl || is_limit || is_secure;
   // Grant register itself is never opened to non-secure masters
   assign permitted = is_secure ? !pprot[PROT_NONSECURE_BIT]
                      : (!pprot[PROT_NONSECURE_BIT]
                         || state.secure_grant); // see RQ3

   assign setup = psel && !penable;
   assign wr_fire = clk_en && psel && penable && pwrite
                    && mapped && permitted;

   assign pready = clk_en;
   assign pslverr = psel && penable && !(mapped && permitted);
   assign prdata = state.rdata;

   // Per-port QoS value path
   generate
      for (genvar p = 0; p < NUM_PORTS; p++)
      begin : g_port
         assign wr_regulate[p] = state.control[p][CTRL_QV_WR_BIT]
                                 && (wr_target[p] != 12'h000); // see RQ18
         assign rd_qv_enable[p] = state.control[p][CTRL_QV_RD_BIT]
                                  && (rd_target[p] != 12'h000); // see RQ9
         assign wr_qv_enable[p] = wr_regulate[p]; // see RQ10
         assign quiesce_high[p] =
            state.control[p][CTRL_QUIESCE_BIT]; // see RQ4
         assign rd_period_mode[p] =
            state.control[p][CTRL_RD_PERIOD_BIT]; // see RQ5
         assign wr_period_mode[p] =
            state.control[p][CTRL_WR_PERIOD_BIT]; // see RQ6

         qos_value_select u_select (
            .fixed_select (qos_fixed_select[p]),
            .fixed_value  (state.wqos_fixed[p]),
            .regulate     (wr_regulate[p]),
            .regulated    (regulated_wqos[p]),
            .qos_min      (wqos_min[p]),
            .qos_max      (wqos_max[p]),
            .incoming     (write_qos_in[p]),
            .applied      (applied[p]),
            .live         (live[p])
         );
      end
   endgenerate

   assign write_qos_out = state.wqos_out;

   // Outstanding-transaction limiters, lite ports only
   ot_limit_if ot_rd[NUM_LITE] ();
   ot_limit_if ot_wr[NUM_LITE] ();

   generate
      for (genvar l = 0; l < NUM_LITE; l++)
      begin : g_lite
         assign ot_rd[l].int_part =
            state.limit[l][LIMIT_RD_INT_LSB +: 6]; // see RQ12
         assign ot_rd[l].frac_part =
            state.limit[l][LIMIT_RD_FRAC_LSB +: 8]; // see RQ12
         assign ot_rd[l].enable = state.ot_rd_on[l];
         assign ot_rd[l].issue = ar_issue[l];
         assign ot_wr[l].int_part =
            state.limit[l][LIMIT_WR_INT_LSB +: 6]; // see RQ13
         assign ot_wr[l].frac_part =
            state.limit[l][LIMIT_WR_FRAC_LSB +: 8]; // see RQ13
         assign ot_wr[l].enable = state.ot_wr_on[l];
         assign ot_wr[l].issue = aw_issue[l];
         assign ot_rd_limit[l] = ot_rd[l].limit;
         assign ot_rd_limited[l] = ot_rd[l].active;
         assign ot_wr_limit[l] = ot_wr[l].limit;
         assign ot_wr_limited[l] = ot_wr[l].active;

         ot_limit_average #(.HW_MAX(OT_RD_HW_MAX)) u_rd_limit (
            .pclk    (pclk),
            .presetn (presetn),
            .clk_en  (clk_en),
            .lim     (ot_rd[l])
         );

         ot_limit_average #(.HW_MAX(OT_WR_HW_MAX)) u_wr_limit (
            .pclk    (pclk),
            .presetn (presetn),
            .clk_en  (clk_en),
            .lim     (ot_wr[l])
         );
      end
   endgenerate

   // Read mux; unmapped and refused reads return zero
   always_comb
   begin
      read_value = 32'h0000_0000;
      if (is_wqos)
      begin
         read_value[WQOS_LIVE_LSB +: 4] = live[port_idx]; // see RQ2
         read_value[WQOS_FIXED_LSB +: 4] = state.wqos_fixed[port_idx];
      end
      else if (is_ctrl)
         read_value = state.control[port_idx];
      else if (is_limit)
         read_value = state.limit[port_idx[1:0]];
      else if (is_secure)
         read_value[SECURE_GRANT_BIT] = state.secure_grant;
   end

   always_comb
   begin
      next_state = state;
      next_state.wqos_out = applied;
      if (setup)
         next_state.rdata = (!pwrite && mapped && permitted)
                            ? read_value : 32'h0000_0000; // see RQ3
      if (wr_fire)
      begin
         if (is_wqos)
            next_state.wqos_fixed[port_idx] =
               pwdata[WQOS_FIXED_LSB +: 4]; // see RQ21
         if (is_ctrl)
            next_state.control[port_idx] = pwdata
               & ((port_idx < 3'(NUM_LITE)) ? CTRL_MASK_LITE
                                            : CTRL_MASK_ACE); // see RQ7
         if (is_limit)
            next_state.limit[port_idx[1:0]] =
               pwdata & LIMIT_WRITE_MASK; // see RQ21
         if (is_secure)
            next_state.secure_grant = pwdata[SECURE_GRANT_BIT];
      end
      // Enables follow the register only while nothing is outstanding
      for (int l = 0; l < NUM_LITE; l++)
      begin
         if (ot_rd_idle[l])
            next_state.ot_rd_on[l] =
               state.control[l][CTRL_OT_RD_BIT]; // see RQ11
         if (ot_wr_idle[l])
            next_state.ot_wr_on[l] =
               state.control[l][CTRL_OT_WR_BIT]; // see RQ8
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= '0; // see RQ21
      else if (clk_en)
         state <= next_state;
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence ctrl0_write;
      wr_fire && is_ctrl && (port_idx == 3'h0);
   endsequence

   sequence wqos0_read_setup;
      clk_en && setup && !pwrite && is_wqos && (port_idx == 3'h0)
      && permitted;
   endsequence

   chk_override_value: assert property ( // see RQ1
      clk_en && qos_fixed_select[0] && !wr_regulate[0]
      |=> write_qos_out[0] == $past(state.wqos_fixed[0]))
      else $error("fixed write QoS not applied");

   chk_live_field: assert property ( // see RQ2
      wqos0_read_setup ##0 (qos_fixed_select[0] && wr_regulate[0])
      |=> prdata[11:8] == $past(live[0]))
      else $error("live QoS field wrong on read");

   chk_nonsecure_refused: assert property ( // see RQ3
      clk_en && psel && penable && pwrite && !is_secure
      && pprot[PROT_NONSECURE_BIT] && !state.secure_grant
      |-> pslverr ##1 ($stable(state.control) && $stable(state.limit)
                       && $stable(state.wqos_fixed)))
      else $error("non-secure write was not refused");

   chk_mode_write: assert property ( // see RQ4
      ctrl0_write |=> quiesce_high[0] == $past(pwdata[21])
                      && rd_period_mode[0] == $past(pwdata[20])
                      && wr_period_mode[0] == $past(pwdata[16]))
      else $error("mode bits did not follow write");

   chk_ace_ot_zero: assert property ( // see RQ7
      state.control[3][3:2] == 2'b00 && state.control[4][3:2] == 2'b00)
      else $error("outstanding enable set on full-coherent port");

   chk_ot_change_idle: assert property ( // see RQ11
      (!$changed(state.ot_rd_on[0]) || $past(ot_rd_idle[0]))
      && (!$changed(state.ot_wr_on[0]) || $past(ot_wr_idle[0])))
      else $error("outstanding enable changed while busy");

   chk_qv_enable: assert property ( // see RQ9
      ctrl0_write ##1 (rd_target[0] != 12'h000)
      |-> rd_qv_enable[0] == $past(pwdata[1]))
      else $error("read regulation enable wrong");

   chk_wr_qv_enable: assert property ( // see RQ10
      ctrl0_write ##1 (wr_target[0] != 12'h000)
      |-> wr_qv_enable[0] == $past(pwdata[0]))
      else $error("write regulation enable wrong");

   chk_target_zero: assert property ( // see RQ18
      clk_en && qos_fixed_select[0] && wr_target[0] == 12'h000
      |-> !wr_qv_enable[0]
          ##1 (write_qos_out[0] == $past(state.wqos_fixed[0])))
      else $error("write regulation on with zero target");

   chk_reserved_zero: assert property ( // see RQ21
      wqos0_read_setup |=> prdata[31:12] == 20'h00000
                           && prdata[7:4] == 4'h0)
      else $error("reserved bits not zero");

   chk_limit_absent: assert property ( // see RQ17
      psel && penable && in_ports && reg_off == LIMIT_OFFSET
      && port_idx >= 3'(NUM_LITE) |-> pslverr)
      else $error("limit register answered on full-coherent port");

   chk_clamp_range: assert property ( // see RQ19
      qos_fixed_select[0] && wr_regulate[0]
      && wqos_min[0] <= wqos_max[0]
      |-> live[0] >= wqos_min[0] && live[0] <= wqos_max[0])
      else $error("regulated QoS outside range");

   chk_refused_read: assert property ( // see RQ3
      clk_en && setup && !pwrite && !is_secure
      && pprot[PROT_NONSECURE_BIT] && !state.secure_grant
      |=> prdata == 32'h0000_0000)
      else $error("refused read returned data");

   chk_grant_secure: assert property ( // see RQ3
      clk_en && psel && penable && pwrite && is_secure
      && pprot[PROT_NONSECURE_BIT] |=> $stable(state.secure_grant))
      else $error("non-secure write changed the grant");

   chk_rd_limit_field: assert property ( // see RQ12
      clk_en && state.ot_rd_on[0] && state.limit[0][23:16] == 8'h00
      && state.limit[0][29:24] != 6'h00
      && {1'b0, state.limit[0][29:24]} <= OT_RD_HW_MAX
      |=> ot_rd_limit[0] == {1'b0, $past(state.limit[0][29:24])})
      else $error("read limit not taken from its field");

   chk_wr_limit_field: assert property ( // see RQ13
      clk_en && state.ot_wr_on[0] && state.limit[0][7:0] == 8'h00
      && state.limit[0][13:8] != 6'h00
      && {1'b0, state.limit[0][13:8]} <= OT_WR_HW_MAX
      |=> ot_wr_limit[0] == {1'b0, $past(state.limit[0][13:8])})
      else $error("write limit not taken from its field");

endmodule

// >>> tb/lite_master_model.sv
`timescale 1ns/10ps
module lite_master_model
   import qos_ot_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic [NUM_LITE-1:0] rd_go,
   input  wire logic [NUM_LITE-1:0] wr_go,
   input  wire logic [NUM_LITE-1:0] rd_busy,
   input  wire logic [NUM_LITE-1:0] wr_busy,
   output logic      [NUM_LITE-1:0] ar_issue,
   output logic      [NUM_LITE-1:0] aw_issue,
   output logic      [NUM_LITE-1:0] rd_idle,
   output logic      [NUM_LITE-1:0] wr_idle
);
   // One issue pulse per cycle of request
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ar_issue <= '0;
         aw_issue <= '0;
      end
      else
      begin
         ar_issue <= rd_go;
         aw_issue <= wr_go;
      end
   end
   // Busy means transactions still outstanding
   assign rd_idle = ~rd_busy;
   assign wr_idle = ~wr_busy;
endmodule

// >>> tb/testbench.sv
`timescale 1ns/10ps
module testbench
   import qos_ot_pkg::*;
();
   logic                       pclk = 0, presetn = 0, clk_en = 1;
   logic                       psel = 0, penable = 0, pwrite = 0;
   logic [11:0]                paddr = '0;
   logic [31:0]                pwdata = '0, prdata, rd;
   logic [2:0]                 pprot = '0;
   logic                       pready, pslverr, err;
   logic [NUM_PORTS-1:0]       sel = '0, qh, rpm, wpm, rqe, wqe;
   logic [NUM_PORTS-1:0][3:0]  qin = '0, regq = '0, qmin = '0, qmax = '0;
   logic [NUM_PORTS-1:0][3:0]  qout;
   logic [NUM_PORTS-1:0][11:0] rtg = '0, wtg = '0;
   logic [NUM_LITE-1:0]        rgo = '0, wgo = '0, rbusy = '0, wbusy = '0;
   logic [NUM_LITE-1:0]        ridle, widle, ari, awi, rltd, wltd;
   logic [NUM_LITE-1:0][6:0]   rlim, wlim;
   int                         n_mismatch = 0, compares = 0;

   always #25 pclk = ~pclk;

   lite_master_model master (.pclk(pclk), .presetn(presetn), .rd_go(rgo),
      .wr_go(wgo), .rd_busy(rbusy), .wr_busy(wbusy), .ar_issue(ari),
      .aw_issue(awi), .rd_idle(ridle), .wr_idle(widle));

   qos_ot_regulation_config dut (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pprot(pprot), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .qos_fixed_select(sel),
      .write_qos_in(qin), .regulated_wqos(regq), .wqos_min(qmin),
      .wqos_max(qmax), .rd_target(rtg), .wr_target(wtg),
      .write_qos_out(qout), .quiesce_high(qh), .rd_period_mode(rpm),
      .wr_period_mode(wpm), .rd_qv_enable(rqe), .wr_qv_enable(wqe),
      .ot_rd_idle(ridle), .ot_wr_idle(widle), .ar_issue(ari),
      .aw_issue(awi), .ot_rd_limit(rlim), .ot_wr_limit(wlim),
      .ot_rd_limited(rltd), .ot_wr_limited(wltd));

   task end_sim;
      $display("Compares %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task check(input string what, input logic [31:0] seen,
              input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; read data and error taken at the pready edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1)
      begin
         n_mismatch++;
         end_sim;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task settle;
      repeat (3) @(posedge pclk);
   endtask

   task issue(input int times);
      repeat (times)
      begin
         @(posedge pclk);
         wgo[0] <= 1'b1;
         @(posedge pclk);
         wgo[0] <= 1'b0;
      end
   endtask

   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int p = 0; p < NUM_PORTS; p++)
         for (int o = 0; o < 12; o += 4)
         begin
            if (p >= NUM_LITE && o == 8)
               continue;
            apb(1'b0, 12'(p * 16 + o), '0);
            check("reset value", rd, 32'h0);
         end
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         apb(1'b1, 12'(p * 16), '1);
         apb(1'b0, 12'(p * 16), '0);
         check("fixed qos", rd, 32'h0000_000f);
         apb(1'b1, 12'(p * 16 + 4), '1);
         apb(1'b0, 12'(p * 16 + 4), '0);
         check("control", rd, p < 3 ? 32'h0031_000f : 32'h0031_0003);
         apb(1'b1, 12'(p * 16 + 8), '1);
         check("limit error", err, 32'(p >= 3));
         apb(1'b0, 12'(p * 16 + 8), '0);
         check("limit", rd, p < 3 ? 32'h3fff_3fff : 32'h0);
      end
      settle;
      check("quiesce", qh, 32'h1f);
      check("read period", rpm, 32'h1f);
      check("write period", wpm, 32'h1f);
      check("read qv off", rqe, 32'h0);
      check("limit above depth", wlim[1], 32'h20);
      check("read limited", rltd, 32'h7);
      check("write limited", wltd, 32'h7);
      rtg <= '1;
      wtg <= '1;
      settle;
      check("read qv on", rqe, 32'h1f);
      check("write qv on", wqe, 32'h1f);
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         apb(1'b1, 12'(p * 16), '0);
         apb(1'b1, 12'(p * 16 + 4), '0);
         if (p < 3)
            apb(1'b1, 12'(p * 16 + 8), '0);
      end
      // Non-secure access before and after the grant
      pprot <= 3'b010;
      apb(1'b1, 12'h010, 32'h5);
      check("refused", err, 32'h1);
      apb(1'b0, 12'h010, '0);
      check("refused data", rd, 32'h0);
      apb(1'b1, 12'h050, 32'h1);
      check("grant refused", err, 32'h1);
      pprot <= 3'b000;
      apb(1'b1, 12'h050, 32'h1);
      pprot <= 3'b010;
      apb(1'b1, 12'h010, 32'h5);
      apb(1'b0, 12'h010, '0);
      check("granted", rd, 32'h5);
      pprot <= 3'b000;
      apb(1'b1, 12'h050, '0);
      // Fixed and regulated write QoS on port 0
      apb(1'b1, 12'h000, 32'h3);
      sel[0] <= 1'b1;
      settle;
      check("fixed applied", qout[0], 32'h3);
      sel[0] <= 1'b0;
      qin[0] <= 4'h7;
      settle;
      check("pass through", qout[0], 32'h7);
      sel[0] <= 1'b1;
      qin[0] <= 4'h0;
      regq[0] <= 4'hf;
      qmax[0] <= 4'ha;
      qmin[0] <= 4'h2;
      apb(1'b1, 12'h004, 32'h1);
      settle;
      check("clamp max", qout[0], 32'ha);
      apb(1'b0, 12'h000, '0);
      check("live field", rd, 32'h0000_0a03);
      regq[0] <= 4'h0;
      settle;
      check("clamp min", qout[0], 32'h2);
      wtg[0] <= '0;
      settle;
      check("zero target", qout[0], 32'h3);
      apb(1'b0, 12'h000, '0);
      check("live off", rd, 32'h3);
      apb(1'b1, 12'h004, '0);
      // Outstanding limits on port 0
      wbusy[0] <= 1'b1;
      apb(1'b1, 12'h008, 32'h0300_0480);
      apb(1'b1, 12'h004, 32'hc);
      settle;
      check("deferred", wltd[0], 32'h0);
      check("read limit", rlim[0], 32'h3);
      wbusy[0] <= 1'b0;
      settle;
      check("enabled", wltd[0], 32'h1);
      check("write limit", wlim[0], 32'h4);
      issue(2);
      settle;
      check("bonus", wlim[0], 32'h5);
      issue(1);
      settle;
      check("no bonus", wlim[0], 32'h4);
      apb(1'b1, 12'h008, 32'h0300_0400);
      issue(2);
      settle;
      check("integer only", wlim[0], 32'h4);
      apb(1'b1, 12'h008, '0);
      settle;
      check("hardware limit", wlim[0], 32'h20);
      check("not limited", wltd[0], 32'h0);
      end_sim;
   end
endmodule
